// file: design/bst_pkg.sv
package bst_pkg;

	// ----------------------------------------
	// clocks and divisor arithmetic
	// ----------------------------------------
	localparam int unsigned CLK_HZ     = 25_000_000; // clk_sys rate
	localparam int unsigned SYS_HZ_60  = 1_022_730;  // 1.02273E6 Hz, 60 Hz television variant
	localparam int unsigned SYS_HZ_50  = 985_250;    // 0.98525E6 Hz, 50 Hz television variant
	localparam int unsigned DIV_OFFSET = 100;
	localparam int unsigned DIV_SPLIT  = 256;        // divisor = high * 256 + low
	localparam logic [15:0] DIV_SLOW   = 16'hFFFF;   // unimplemented selection, well below 50 baud
	localparam int unsigned FIFO_DEPTH = 256;

	// ----------------------------------------
	// line status word bit positions
	// ----------------------------------------
	localparam int unsigned ST_PARITY  = 0;
	localparam int unsigned ST_FRAME   = 1;
	localparam int unsigned ST_OVERRUN = 2;
	localparam int unsigned ST_EMPTY   = 3;
	localparam int unsigned ST_CTS     = 4;
	localparam int unsigned ST_DSR     = 6;
	localparam int unsigned ST_BREAK   = 7;

	// ----------------------------------------
	// setup byte order and field layout
	// ----------------------------------------
	localparam logic [2:0] CFG_CTRL   = 3'h0;
	localparam logic [2:0] CFG_CMD    = 3'h1;
	localparam logic [2:0] CFG_DIV_LO = 3'h2;
	localparam logic [2:0] CFG_DIV_HI = 3'h3;
	localparam logic [2:0] CFG_MAX    = 3'h4;
	localparam int unsigned CTRL_BAUD_LSB = 0;
	localparam int unsigned CTRL_BAUD_MSB = 3;
	localparam int unsigned CTRL_WL_LSB   = 5;
	localparam int unsigned CTRL_WL_MSB   = 6;
	localparam int unsigned CTRL_STOP     = 7;
	localparam int unsigned CMD_HS        = 0;
	localparam int unsigned CMD_PAR_LSB   = 5;
	localparam int unsigned CMD_PAR_MSB   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h06;
	localparam logic [7:0] CMD_RESET  = 8'h00;
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_ODD  = 3'h1;
	localparam logic [2:0] PAR_EVEN = 3'h2;
	localparam logic [2:0] PAR_MARK = 3'h3;
	localparam logic [7:0] CHR_CR    = 8'h0D;
	localparam logic [7:0] CHR_LF    = 8'h0A;
	localparam logic [7:0] LFN_LIMIT = 8'h7F;

	typedef enum logic {TX_IDLE, TX_SHIFT} bst_tx_e;
	typedef enum logic {RX_IDLE, RX_BITS} bst_rx_e;
	typedef logic [15:0] bst_div_tab_t [16];

	// divisor per baud code, half bit period minus offset
	function automatic bst_div_tab_t bst_mk_tab(int unsigned hz);
		bst_div_tab_t t;
		int unsigned  r;
		for (int i = 0; i < 16; i++) begin
			case (i)
				1: r = 50;
				2: r = 75;
				3: r = 110;
				4: r = 150;
				5: r = 300;
				6: r = 600;
				7: r = 1200;
				8: r = 1800;
				9: r = 2400;
				10: r = 4800;
				default: r = 0;
			endcase
			t[i] = (r == 0) ? DIV_SLOW : 16'(hz / r / 2 - DIV_OFFSET);
		end
		return t;
	endfunction

	localparam bst_div_tab_t DIV_TAB_60 = bst_mk_tab(SYS_HZ_60);
	localparam bst_div_tab_t DIV_TAB_50 = bst_mk_tab(SYS_HZ_50);

	// parity bit for a byte whose unused bits are zero
	function automatic logic bst_par(logic [2:0] mode, logic [7:0] d);
		case (mode)
			PAR_ODD: return ~^d;
			PAR_EVEN: return ^d;
			PAR_MARK: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

endpackage

// file: design/bst_fifo_if.sv
`timescale 1ns/1ns
interface bst_fifo_if #(parameter int W = 8);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;
	logic         flush;
	logic         empty;
	modport fifo (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data, empty);
	modport user (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data, empty);
endinterface

// file: design/bst_fifo.sv
`timescale 1ns/1ns
module bst_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = bst_pkg::FIFO_DEPTH
) (
	input  wire logic clk_sys,
	input  wire logic nrst,
	bst_fifo_if.fifo  f
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 4 || DEPTH != (1 << AW)) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least 4");
	end

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] wr_ptr_d;
	logic [AW-1:0] rd_ptr_q;
	logic [AW-1:0] rd_ptr_d;
	logic [AW-1:0] used;
	logic          do_wr;

	// one slot stays free, so at most DEPTH-1 entries
	assign used       = wr_ptr_q - rd_ptr_q;
	assign f.wr_ready = (used != AW'(DEPTH - 1));
	assign f.rd_valid = (used != '0);
	assign f.empty    = ~f.rd_valid;
	assign f.rd_data  = mem[rd_ptr_q];
	assign do_wr      = f.wr_valid & f.wr_ready & ~f.flush;

	// pointer update, flush drops everything
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		if (f.flush) begin
			wr_ptr_d = '0;
			rd_ptr_d = '0;
		end else begin
			if (do_wr)
				wr_ptr_d = wr_ptr_q + 1'b1;
			if (f.rd_ready && f.rd_valid)
				rd_ptr_d = rd_ptr_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_sys) begin
		if (do_wr)
			mem[wr_ptr_q] <= f.wr_data;
	end
endmodule

// file: design/bst_serial_port.sv
`timescale 1ns/1ns
module bst_serial_port #(
	parameter int FIFO_DEPTH = bst_pkg::FIFO_DEPTH
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       pal_sel,
	input  wire logic       open_req,
	input  wire logic       close_req,
	input  wire logic [7:0] lfn,
	input  wire logic       cfg_valid,
	input  wire logic [7:0] cfg_byte,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	input  wire logic       rx_req,
	output logic [7:0]      rx_data,
	output logic            rx_hit,
	input  wire logic       status_rd,
	output logic [7:0]      line_status_word,
	output logic            tx_busy,
	output logic            channel_open,
	input  wire logic       bus_hold,
	output logic            pace_evt,
	input  wire logic       rxd,
	input  wire logic       cts_n,
	input  wire logic       dcd_n,
	input  wire logic       dsr_n,
	output logic            txd,
	output logic            rts_n,
	output logic            dtr_n
);
	if (FIFO_DEPTH < 4) begin : g_bad_depth
		$error("fifo depth too small");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] meta_q;
	logic [3:0] pin_q;
	logic       rxd_prev_q;
	logic       rxd_s;
	logic       cts_off;
	logic       dcd_off;
	logic       dsr_off;

	// two flops on every pin, idle high
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_q     <= 4'hF;
			pin_q      <= 4'hF;
			rxd_prev_q <= 1'b1;
		end else begin
			meta_q     <= {dsr_n, dcd_n, cts_n, rxd};
			pin_q      <= meta_q;
			rxd_prev_q <= pin_q[0];
		end
	end
	assign rxd_s   = pin_q[0];
	assign cts_off = pin_q[1];
	assign dcd_off = pin_q[2];
	assign dsr_off = pin_q[3];

	// ----------------------------------------
	// fifos
	// ----------------------------------------
	bst_fifo_if #(.W(8)) txf ();
	bst_fifo_if #(.W(8)) rxf ();
	bst_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txf (.clk_sys(clk_sys), .nrst(nrst), .f(txf));
	bst_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rxf (.clk_sys(clk_sys), .nrst(nrst), .f(rxf));

	logic flush;
	assign flush     = open_req | close_req;
	assign txf.flush = flush;
	assign rxf.flush = flush;

	// writer held off while full or closed
	assign txf.wr_valid = tx_valid & channel_open & ~flush;
	assign txf.wr_data  = tx_data;
	assign tx_ready     = channel_open & txf.wr_ready & ~flush;

	// ----------------------------------------
	// channel setup
	// ----------------------------------------
	logic       open_q;
	logic       open_d;
	logic [2:0] cfg_idx_q;
	logic [2:0] cfg_idx_d;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] cmd_q;
	logic [7:0] cmd_d;
	logic [7:0] div_lo_q;
	logic [7:0] div_lo_d;
	logic [7:0] div_hi_q;
	logic [7:0] div_hi_d;
	logic [7:0] lfn_q;
	logic [7:0] lfn_d;

	always_comb begin
		open_d    = open_q;
		cfg_idx_d = cfg_idx_q;
		ctrl_d    = ctrl_q;
		cmd_d     = cmd_q;
		div_lo_d  = div_lo_q;
		div_hi_d  = div_hi_q;
		lfn_d     = lfn_q;
		if (close_req) begin
			open_d = 1'b0;
		end else if (open_req) begin
			open_d    = 1'b1;
			cfg_idx_d = bst_pkg::CFG_CTRL;
			ctrl_d    = bst_pkg::CTRL_RESET;
			cmd_d     = bst_pkg::CMD_RESET;
			div_lo_d  = 8'h00;
			div_hi_d  = 8'h00;
			lfn_d     = lfn;
		end else if (cfg_valid && open_q && cfg_idx_q != bst_pkg::CFG_MAX) begin
			// setup bytes land in order, extras ignored
			case (cfg_idx_q)
				bst_pkg::CFG_CTRL: ctrl_d = cfg_byte;
				bst_pkg::CFG_CMD: cmd_d = cfg_byte;
				bst_pkg::CFG_DIV_LO: div_lo_d = cfg_byte;
				default: div_hi_d = cfg_byte;
			endcase
			cfg_idx_d = cfg_idx_q + 3'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			open_q    <= 1'b0;
			cfg_idx_q <= bst_pkg::CFG_CTRL;
			ctrl_q    <= bst_pkg::CTRL_RESET;
			cmd_q     <= bst_pkg::CMD_RESET;
			div_lo_q  <= 8'h00;
			div_hi_q  <= 8'h00;
			lfn_q     <= 8'h00;
		end else begin
			open_q    <= open_d;
			cfg_idx_q <= cfg_idx_d;
			ctrl_q    <= ctrl_d;
			cmd_q     <= cmd_d;
			div_lo_q  <= div_lo_d;
			div_hi_q  <= div_hi_d;
			lfn_q     <= lfn_d;
		end
	end
	assign channel_open = open_q;

	// decoded line format
	logic        hs;
	logic [2:0]  par_mode;
	logic        par_on;
	logic [3:0]  wl;
	logic [3:0]  frame_len;
	logic [3:0]  baud_code;
	logic [15:0] div_eff;
	logic [16:0] half_per;
	logic [17:0] bit_per;

	assign hs        = cmd_q[bst_pkg::CMD_HS];
	assign par_mode  = cmd_q[bst_pkg::CMD_PAR_MSB:bst_pkg::CMD_PAR_LSB];
	assign par_on    = (par_mode != bst_pkg::PAR_NONE);
	assign wl        = 4'h8 - {2'h0, ctrl_q[bst_pkg::CTRL_WL_MSB:bst_pkg::CTRL_WL_LSB]};
	assign frame_len = 4'h2 + wl + {3'h0, par_on} + {3'h0, ctrl_q[bst_pkg::CTRL_STOP]};
	assign baud_code = ctrl_q[bst_pkg::CTRL_BAUD_MSB:bst_pkg::CTRL_BAUD_LSB];
	assign div_eff   = (baud_code == 4'h0)
		? 16'(32'(div_hi_q) * bst_pkg::DIV_SPLIT + 32'(div_lo_q))
		: (pal_sel ? bst_pkg::DIV_TAB_50[baud_code] : bst_pkg::DIV_TAB_60[baud_code]);
	assign half_per  = {1'b0, div_eff} + 17'(bst_pkg::DIV_OFFSET);
	assign bit_per   = {half_per, 1'b0};

	// ----------------------------------------
	// timer events at system rate
	// ----------------------------------------
	logic [24:0] acc_q;
	logic [24:0] acc_d;
	logic [25:0] acc_sum;
	logic        tick_q;
	logic        tick_d;

	// fractional divider from clk_sys down to system rate, frozen during bus transfers
	always_comb begin
		acc_sum = {1'b0, acc_q} + 26'(pal_sel ? bst_pkg::SYS_HZ_50 : bst_pkg::SYS_HZ_60);
		acc_d   = acc_q;
		tick_d  = 1'b0;
		if (!bus_hold) begin
			if (acc_sum >= 26'(bst_pkg::CLK_HZ)) begin
				acc_d  = 25'(acc_sum - 26'(bst_pkg::CLK_HZ));
				tick_d = 1'b1;
			end else begin
				acc_d = acc_sum[24:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			acc_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			acc_q  <= acc_d;
			tick_q <= tick_d;
		end
	end
	assign pace_evt = tick_q;

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	bst_pkg::bst_tx_e tx_st_q;
	bst_pkg::bst_tx_e tx_st_d;
	logic [17:0]      tx_cnt_q;
	logic [17:0]      tx_cnt_d;
	logic [3:0]       tx_bit_q;
	logic [3:0]       tx_bit_d;
	logic [11:0]      tx_sh_q;
	logic [11:0]      tx_sh_d;
	logic             txd_q;
	logic             txd_d;
	logic             lf_pend_q;
	logic             lf_pend_d;
	logic             busy_q;
	logic             cts_miss;
	logic [7:0]       tx_byte;

	always_comb begin
		tx_st_d     = tx_st_q;
		tx_cnt_d    = tx_cnt_q;
		tx_bit_d    = tx_bit_q;
		tx_sh_d     = tx_sh_q;
		txd_d       = txd_q;
		lf_pend_d   = lf_pend_q;
		txf.rd_ready = 1'b0;
		cts_miss    = 1'b0;
		tx_byte     = lf_pend_q ? bst_pkg::CHR_LF : txf.rd_data;
		if (flush || !open_q) begin
			tx_st_d   = bst_pkg::TX_IDLE;
			txd_d     = 1'b1;
			lf_pend_d = 1'b0;
		end else begin
			case (tx_st_q)
				bst_pkg::TX_IDLE: begin
					txd_d = 1'b1;
					if (lf_pend_q || txf.rd_valid) begin
						if (hs && cts_off) begin
							cts_miss = 1'b1;
						end else begin
							// build frame: start, data, parity, stops
							tx_sh_d = '1;
							tx_sh_d[0] = 1'b0;
							for (int i = 0; i < 8; i++) begin
								if (4'(i) < wl)
									tx_sh_d[i + 1] = tx_byte[i];
							end
							if (par_on)
								tx_sh_d[4'h1 + wl] = bst_pkg::bst_par(par_mode, tx_byte & ~(8'hFF << wl));
							txf.rd_ready = ~lf_pend_q;
							lf_pend_d = ~lf_pend_q && (lfn_q > bst_pkg::LFN_LIMIT)
								&& (tx_byte == bst_pkg::CHR_CR);
							tx_st_d  = bst_pkg::TX_SHIFT;
							tx_cnt_d = '0;
							tx_bit_d = 4'h0;
							txd_d    = 1'b0;
						end
					end
				end
				bst_pkg::TX_SHIFT: begin
					if (tick_q) begin
						if (tx_cnt_q == bit_per - 18'h1) begin
							tx_cnt_d = '0;
							tx_bit_d = tx_bit_q + 4'h1;
							tx_sh_d  = {1'b1, tx_sh_q[11:1]};
							if (tx_bit_q == frame_len - 4'h1) begin
								tx_st_d = bst_pkg::TX_IDLE;
								txd_d   = 1'b1;
							end else begin
								txd_d = tx_sh_q[1];
							end
						end else begin
							tx_cnt_d = tx_cnt_q + 18'h1;
						end
					end
				end
				default: tx_st_d = bst_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_st_q   <= bst_pkg::TX_IDLE;
			tx_cnt_q  <= '0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= '1;
			txd_q     <= 1'b1;
			lf_pend_q <= 1'b0;
			busy_q    <= 1'b0;
		end else begin
			tx_st_q   <= tx_st_d;
			tx_cnt_q  <= tx_cnt_d;
			tx_bit_q  <= tx_bit_d;
			tx_sh_q   <= tx_sh_d;
			txd_q     <= txd_d;
			lf_pend_q <= lf_pend_d;
			busy_q    <= txf.rd_valid | (tx_st_d != bst_pkg::TX_IDLE) | lf_pend_d;
		end
	end
	assign txd     = txd_q;
	assign tx_busy = busy_q;

	// modem outputs high when closed or three-wire
	assign rts_n = ~(open_q & hs);
	assign dtr_n = ~(open_q & hs);

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	bst_pkg::bst_rx_e rx_st_q;
	bst_pkg::bst_rx_e rx_st_d;
	logic [17:0]      rx_cnt_q;
	logic [17:0]      rx_cnt_d;
	logic [3:0]       rx_idx_q;
	logic [3:0]       rx_idx_d;
	logic [7:0]       rx_byte_q;
	logic [7:0]       rx_byte_d;
	logic             rx_par_q;
	logic             rx_par_d;
	logic [17:0]      rx_target;
	logic [7:0]       ev;

	assign rx_target    = (rx_idx_q == 4'h0) ? {1'b0, half_per} : bit_per;
	assign rxf.wr_data  = rx_byte_q;

	always_comb begin
		rx_st_d      = rx_st_q;
		rx_cnt_d     = rx_cnt_q;
		rx_idx_d     = rx_idx_q;
		rx_byte_d    = rx_byte_q;
		rx_par_d     = rx_par_q;
		rxf.wr_valid = 1'b0;
		ev           = 8'h00;
		if (flush || !open_q || bus_hold) begin
			rx_st_d = bst_pkg::RX_IDLE;
		end else begin
			case (rx_st_q)
				bst_pkg::RX_IDLE: begin
					// falling edge on the line opens a frame
					if (rxd_prev_q && !rxd_s && !(hs && dcd_off)) begin
						rx_st_d   = bst_pkg::RX_BITS;
						rx_cnt_d  = '0;
						rx_idx_d  = 4'h0;
						rx_byte_d = 8'h00;
					end
				end
				bst_pkg::RX_BITS: begin
					if (tick_q && rx_cnt_q == rx_target - 18'h1) begin
						rx_cnt_d = '0;
						rx_idx_d = rx_idx_q + 4'h1;
						if (rx_idx_q == 4'h0) begin
							if (rxd_s)
								rx_st_d = bst_pkg::RX_IDLE; // false start
						end else if (rx_idx_q <= wl) begin
							rx_byte_d[3'(rx_idx_q - 4'h1)] = rxd_s;
						end else if (par_on && rx_idx_q == wl + 4'h1) begin
							rx_par_d = rxd_s;
						end else begin
							// stop bit: close the character
							rx_st_d = bst_pkg::RX_IDLE;
							ev[bst_pkg::ST_FRAME]  = ~rxd_s;
							ev[bst_pkg::ST_BREAK]  = ~rxd_s && rx_byte_q == 8'h00 && !(par_on && rx_par_q);
							ev[bst_pkg::ST_PARITY] = par_on && (rx_par_q != bst_pkg::bst_par(par_mode, rx_byte_q));
							ev[bst_pkg::ST_DSR]    = hs && dsr_off;
							ev[bst_pkg::ST_OVERRUN] = ~rxf.wr_ready;
							rxf.wr_valid = 1'b1;
						end
					end else if (tick_q) begin
						rx_cnt_d = rx_cnt_q + 18'h1;
					end
				end
				default: rx_st_d = bst_pkg::RX_IDLE;
			endcase
		end
		ev[bst_pkg::ST_CTS] = cts_miss;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rx_st_q   <= bst_pkg::RX_IDLE;
			rx_cnt_q  <= '0;
			rx_idx_q  <= 4'h0;
			rx_byte_q <= 8'h00;
			rx_par_q  <= 1'b0;
		end else begin
			rx_st_q   <= rx_st_d;
			rx_cnt_q  <= rx_cnt_d;
			rx_idx_q  <= rx_idx_d;
			rx_byte_q <= rx_byte_d;
			rx_par_q  <= rx_par_d;
		end
	end

	// ----------------------------------------
	// host reads and line status word
	// ----------------------------------------
	logic [7:0] st_q;
	logic [7:0] st_d;
	logic [7:0] rx_data_q;
	logic [7:0] rx_data_d;
	logic       rx_hit_q;
	logic       rx_hit_d;

	assign rxf.rd_ready = rx_req;

	// sticky bits except empty, a new event beats the read clear
	always_comb begin
		st_d = (status_rd ? 8'h00 : st_q) | ev;
		st_d[bst_pkg::ST_EMPTY] = rxf.empty;
		rx_data_d = rx_data_q;
		rx_hit_d  = 1'b0;
		if (rx_req) begin
			rx_data_d = rxf.rd_valid ? rxf.rd_data : 8'h00;
			rx_hit_d  = rxf.rd_valid;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q      <= 8'(1 << bst_pkg::ST_EMPTY);
			rx_data_q <= 8'h00;
			rx_hit_q  <= 1'b0;
		end else begin
			st_q      <= st_d;
			rx_data_q <= rx_data_d;
			rx_hit_q  <= rx_hit_d;
		end
	end
	assign line_status_word = st_q;
	assign rx_data          = rx_data_q;
	assign rx_hit           = rx_hit_q;
endmodule

// file: tb/bst_props.sv
`timescale 1ns/1ns
module bst_props (
	input wire logic       clk_sys,
	input wire logic       nrst,
	input wire logic       open_req,
	input wire logic       close_req,
	input wire logic       tx_ready,
	input wire logic       rx_req,
	input wire logic [7:0] rx_data,
	input wire logic       rx_hit,
	input wire logic [7:0] line_status_word,
	input wire logic       channel_open,
	input wire logic       pace_evt,
	input wire logic       txd,
	input wire logic       rts_n,
	input wire logic       dtr_n
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// channel state and modem lines
	// ----------------------------------------
	a_closed_idle: assert property (!channel_open && $past(!channel_open) |-> txd && rts_n && dtr_n)
		else $error("lines not idle while closed");
	a_close_wins: assert property (close_req |=> !channel_open)
		else $error("channel open after close");
	a_open_rises: assert property (open_req && !close_req |=> channel_open)
		else $error("channel not open after open");
	a_ready_closed: assert property (!channel_open |-> !tx_ready)
		else $error("tx ready while closed");
	a_ready_quiet: assert property (tx_ready |-> !open_req && !close_req)
		else $error("tx ready during open or close");
	// ----------------------------------------
	// receive reads, status and pacing
	// ----------------------------------------
	a_empty_null: assert property ($past(rx_req) && !rx_hit |-> rx_data == 8'h00)
		else $error("empty read not null");
	a_hit_cause: assert property (rx_hit |-> $past(rx_req))
		else $error("read hit without request");
	a_status_gap: assert property (!line_status_word[5])
		else $error("unused status bit set");
	a_pace_gap: assert property (pace_evt |=> (!pace_evt)[*8])
		else $error("pace events too close");
endmodule
bind bst_serial_port bst_props u_bst_props (.*);

// file: tb/bst_modem.sv
`timescale 1ns/1ns
module bst_modem (
	input  wire logic txd,
	input  wire logic rts_n,
	input  wire logic cts_off,
	output logic      rxd,
	output logic      cts_n,
	output logic      dcd_n,
	output logic      dsr_n
);
	// modem loops the line back and answers rts with cts
	assign rxd   = txd;
	assign cts_n = cts_off | rts_n;
	assign dcd_n = 1'b0;
	assign dsr_n = 1'b0;
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
	logic       clk_sys, nrst, open_req, close_req, cfg_valid, tx_valid, rx_req, status_rd, cts_off;
	logic       pal_sel, bus_hold, tprev;
	logic [7:0] cfg_byte, tx_data, rx_data, line_status_word, lfn;
	logic       tx_ready, rx_hit, tx_busy, channel_open, pace_evt, rxd, cts_n, dcd_n, dsr_n, txd, rts_n, dtr_n;
	int         n_errors, n_tests, cyc_cnt, acc, w;
	logic [9:0] rows [2] = '{{8'h00, 2'b11}, {8'h01, 2'b00}};
	// ----------------------------------------
	// clock, device and modem
	// ----------------------------------------
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	bst_serial_port u_bst_serial_port (.clk_sys(clk_sys), .nrst(nrst), .pal_sel(pal_sel), .open_req(open_req),
		.close_req(close_req), .lfn(lfn), .cfg_valid(cfg_valid), .cfg_byte(cfg_byte), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_req(rx_req), .rx_data(rx_data), .rx_hit(rx_hit),
		.status_rd(status_rd), .line_status_word(line_status_word), .tx_busy(tx_busy),
		.channel_open(channel_open), .bus_hold(bus_hold), .pace_evt(pace_evt), .rxd(rxd), .cts_n(cts_n),
		.dcd_n(dcd_n), .dsr_n(dsr_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n));
	bst_modem u_bst_modem (.txd(txd), .rts_n(rts_n), .cts_off(cts_off), .rxd(rxd), .cts_n(cts_n),
		.dcd_n(dcd_n), .dsr_n(dsr_n));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task cyc(int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task open_ch(logic [7:0] c0, logic [7:0] c1);
		@(posedge clk_sys);
		open_req <= 1;
		cyc(1);
		open_req  <= 0;
		cfg_valid <= 1;
		cfg_byte  <= c0;
		cyc(1);
		cfg_byte <= c1;
		cyc(1);
		cfg_byte <= 8'h00;
		cyc(2);
		cfg_valid <= 0;
		cyc(4);
	endtask
	task end_sim;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 90000) begin
			n_errors++;
			end_sim();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{nrst, open_req, close_req, cfg_valid, tx_valid, rx_req, status_rd, cts_off, pal_sel, bus_hold} = 0;
		{cfg_byte, tx_data, lfn} = 0;
		cyc(20);
		nrst <= 1;
		@(negedge clk_sys);
		`CHK({txd, rts_n, channel_open, line_status_word}, {3'b110, 8'h08})
		$display("reset done");
		// line modes: three-wire idles high, handshake drives low
		for (int i = 0; i < 2; i++) begin
			open_ch(8'h06, rows[i][9:2]);
			@(negedge clk_sys);
			`CHK({channel_open, rts_n, dtr_n}, {1'b1, rows[i][1:0]})
		end
		$display("modes done");
		// fill transmit with cts withheld, withheld before the first byte so nothing escapes
		@(posedge clk_sys);
		cts_off  <= 1;
		cyc(3);
		tx_valid <= 1;
		for (int k = 0; k < 300; k++) begin
			tx_data <= k[7:0];
			@(negedge clk_sys);
			if (tx_ready === 1'b1)
				acc++;
			@(posedge clk_sys);
		end
		tx_valid <= 0;
		@(negedge clk_sys);
		`CHK(acc == 255, 1'b1)
		`CHK({txd, tx_busy, line_status_word[4]}, 3'b111)
		// reopen discards the queue, then status read clears
		@(posedge clk_sys);
		open_ch(8'h06, 8'h00);
		cts_off <= 0;
		@(negedge clk_sys);
		`CHK({tx_busy, tx_ready}, 2'b01)
		@(posedge clk_sys);
		status_rd <= 1;
		cyc(1);
		status_rd <= 0;
		cyc(2);
		@(negedge clk_sys);
		`CHK(line_status_word, 8'h08)
		$display("fill done");
		// pace rate per television variant over 2000 cycles
		for (int p = 1; p >= 0; p--) begin
			@(posedge clk_sys);
			pal_sel <= p[0];
			cyc(2);
			acc = 0;
			repeat (2000) begin
				@(negedge clk_sys);
				if (pace_evt === 1'b1)
					acc++;
			end
			`CHK(acc >= (p ? 78 : 81) && acc <= (p ? 79 : 82), 1'b1)
		end
		// bus transfer freezes the pacing events
		@(posedge clk_sys);
		bus_hold <= 1;
		cyc(2);
		acc = 0;
		repeat (60) begin
			@(negedge clk_sys);
			if (pace_evt === 1'b1)
				acc++;
		end
		`CHK(acc, 0)
		@(posedge clk_sys);
		bus_hold <= 0;
		$display("pace done");
		// five-bit words at custom divisor zero, looped back, high file number
		lfn <= 8'h80;
		open_ch(8'h60, 8'h00);
		tx_valid <= 1;
		tx_data  <= 8'hFF;
		cyc(1);
		tx_data <= 8'h0D;
		cyc(1);
		tx_valid <= 0;
		for (w = 0; w < 100 && txd !== 1'b0; w++)
			@(negedge clk_sys);
		acc = 0;
		while (txd === 1'b0 && acc < 300) begin
			@(negedge clk_sys);
			if (pace_evt === 1'b1)
				acc++;
		end
		`CHK(acc >= 199 && acc <= 201, 1'b1)
		// cr frame falls three times, the fourth fall is the line feed start
		acc   = 0;
		tprev = txd;
		for (w = 0; w < 75000 && acc < 4; w++) begin
			@(negedge clk_sys);
			if (tprev === 1'b1 && txd === 1'b0)
				acc++;
			tprev = txd;
		end
		`CHK({txd, tx_busy}, 2'b01)
		for (int j = 0; j < 3; j++) begin
			@(posedge clk_sys);
			rx_req <= 1;
			cyc(1);
			rx_req <= 0;
			@(negedge clk_sys);
			`CHK({rx_hit, rx_data}, j == 0 ? 9'h11F : (j == 1 ? 9'h10D : 9'h000))
		end
		$display("frame done");
		// close returns the lines to idle
		@(posedge clk_sys);
		close_req <= 1;
		cyc(1);
		close_req <= 0;
		cyc(2);
		@(negedge clk_sys);
		`CHK({txd, rts_n, channel_open, tx_busy, tx_ready}, 5'b11000)
		$display("close done");
		end_sim();
	end
endmodule
